// *** logic/frame_policy_pkg.sv ***
package frame_policy_pkg;

    // ------------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam logic [11:0] UVLAN_CTRL_OFS = 12'h328;
    localparam logic [11:0] MAC_CTRL0_OFS = 12'h330;

    // ------------------------------------------------------------------
    // field layout and reset values
    // ------------------------------------------------------------------
    localparam int NUM_PORTS = 6;
    localparam int UVLAN_EN_BIT = 31;
    localparam int MAC0_ALT_BACKOFF_BIT = 7;
    localparam int MAC0_LEN_CHECK_BIT = 3;
    localparam int MAC0_FC_DROP_MODE_BIT = 1;
    localparam int MAC0_AGGR_BACKOFF_BIT = 0;
    localparam logic UVLAN_EN_RST = 1'b0;
    localparam logic [5:0] UVLAN_MASK_RST = 6'h00;
    localparam logic [7:0] MAC_CTRL0_RST = 8'h04;

    // ------------------------------------------------------------------
    // frame classification constants
    // ------------------------------------------------------------------
    localparam logic [15:0] FC_ETHERTYPE = 16'h8808;
    localparam logic [47:0] FC_DEST_ADDR = 48'h0180c2000001;
    // length fields below 1500 are checked
    localparam logic [15:0] LEN_FIELD_LIMIT = 16'h05dc;

    // ------------------------------------------------------------------
    // bus responses
    // ------------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        CLASS_KNOWN,
        CLASS_UNK_VLAN,
        CLASS_UNK_UCAST,
        CLASS_UNK_MCAST
    } unknown_class_t;

endpackage : frame_policy_pkg

// *** logic/switch_frame_policy_control.sv ***
`timescale 1ns/1ns
module switch_frame_policy_control
    import frame_policy_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic frame_valid,
    input wire logic [15:0] frame_type_len,
    input wire logic [47:0] frame_dest_addr,
    input wire logic [15:0] frame_payload_len,
    input wire logic frame_vlan_hit,
    input wire logic frame_unk_ucast,
    input wire logic frame_unk_mcast,
    input wire logic [NUM_PORTS-1:0] port_full_duplex,
    output logic dec_valid,
    output logic dec_drop,
    output logic dec_override,
    output logic [NUM_PORTS-1:0] dec_ports,
    output unknown_class_t dec_class,
    output logic [NUM_PORTS-1:0] port_alt_backoff,
    output logic [NUM_PORTS-1:0] port_aggr_backoff
);

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    logic uvlan_en_q;
    logic [NUM_PORTS-1:0] uvlan_mask_q;
    logic [7:0] mac_ctrl0_q;
    logic aw_held_q;
    logic w_held_q;
    logic [ADDR_W-1:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic do_write;
    logic [31:0] rd_word;
    logic rd_hit;

    assign do_write = aw_held_q && w_held_q && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            aw_addr_q <= '0;
            s_axi_awready <= 1'b1;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_awready <= 1'b1;
        end else if (do_write) begin
            aw_held_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_q <= 1'b0;
            w_data_q <= '0;
            w_strb_q <= '0;
            s_axi_wready <= 1'b1;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_wready <= 1'b1;
        end else if (do_write) begin
            w_held_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            if (aw_addr_q[ADDR_W-1:2] == UVLAN_CTRL_OFS[ADDR_W-1:2]) begin
                s_axi_bresp <= RESP_OKAY;
            end else if (aw_addr_q[ADDR_W-1:2] == MAC_CTRL0_OFS[ADDR_W-1:2])
            begin
                s_axi_bresp <= RESP_OKAY;
            end else begin
                s_axi_bresp <= RESP_SLVERR;
            end
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            uvlan_en_q <= UVLAN_EN_RST;
            uvlan_mask_q <= UVLAN_MASK_RST;
            mac_ctrl0_q <= MAC_CTRL0_RST;
        end else if (do_write) begin
            if (aw_addr_q[ADDR_W-1:2] == UVLAN_CTRL_OFS[ADDR_W-1:2]) begin
                if (w_strb_q[3]) begin
                    uvlan_en_q <= w_data_q[UVLAN_EN_BIT];
                end
                if (w_strb_q[0]) begin
                    uvlan_mask_q <= w_data_q[NUM_PORTS-1:0];
                end
            end else if (aw_addr_q[ADDR_W-1:2] == MAC_CTRL0_OFS[ADDR_W-1:2])
            begin
                if (w_strb_q[0]) begin
                    mac_ctrl0_q <= w_data_q[7:0];
                end
            end
        end
    end

    always_comb begin
        rd_word = '0;
        rd_hit = 1'b1;
        if (s_axi_araddr[ADDR_W-1:2] == UVLAN_CTRL_OFS[ADDR_W-1:2]) begin
            rd_word[UVLAN_EN_BIT] = uvlan_en_q;
            rd_word[NUM_PORTS-1:0] = uvlan_mask_q;
        end else if (s_axi_araddr[ADDR_W-1:2] == MAC_CTRL0_OFS[ADDR_W-1:2])
        begin
            rd_word[7:0] = mac_ctrl0_q;
        end else begin
            rd_hit = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
            s_axi_arready <= 1'b1;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            s_axi_arready <= 1'b0;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // frame policy decision
    // ------------------------------------------------------------------
    logic vlan_unknown;
    logic fc_type_hit;
    logic fc_addr_hit;
    logic fc_drop;
    logic len_drop;
    unknown_class_t class_d;

    assign vlan_unknown = !frame_vlan_hit;
    assign fc_type_hit = frame_type_len == FC_ETHERTYPE;
    assign fc_addr_hit = frame_dest_addr == FC_DEST_ADDR;
    assign fc_drop = mac_ctrl0_q[MAC0_FC_DROP_MODE_BIT] ?
        (fc_type_hit || fc_addr_hit) :
        (fc_type_hit && fc_addr_hit);
    assign len_drop = mac_ctrl0_q[MAC0_LEN_CHECK_BIT] &&
        frame_type_len < LEN_FIELD_LIMIT &&
        frame_payload_len != frame_type_len;

    always_comb begin
        if (vlan_unknown) begin
            class_d = CLASS_UNK_VLAN;
        end else if (frame_unk_ucast) begin
            class_d = CLASS_UNK_UCAST;
        end else if (frame_unk_mcast) begin
            class_d = CLASS_UNK_MCAST;
        end else begin
            class_d = CLASS_KNOWN;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dec_valid <= 1'b0;
            dec_drop <= 1'b0;
            dec_override <= 1'b0;
            dec_ports <= '0;
            dec_class <= CLASS_KNOWN;
        end else begin
            dec_valid <= frame_valid;
            if (frame_valid) begin
                dec_drop <= fc_drop || len_drop;
                dec_class <= class_d;
                dec_override <= vlan_unknown && uvlan_en_q;
                dec_ports <= (vlan_unknown && uvlan_en_q) ?
                    uvlan_mask_q : '0;
            end
        end
    end

    // ------------------------------------------------------------------
    // per-port back-off settings
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            port_alt_backoff <= '0;
            port_aggr_backoff <= '0;
        end else begin
            port_alt_backoff <= mac_ctrl0_q[MAC0_ALT_BACKOFF_BIT] ?
                ~port_full_duplex : '0;
            port_aggr_backoff <= mac_ctrl0_q[MAC0_AGGR_BACKOFF_BIT] ?
                ~port_full_duplex : '0;
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence seq_unk_vlan_on;
        frame_valid && vlan_unknown && uvlan_en_q;
    endsequence

    sequence seq_decided;
        ##1 dec_valid;
    endsequence

    a_uvlan_forward: assert property (seq_unk_vlan_on |-> seq_decided ##0
        (dec_override && dec_ports == $past(uvlan_mask_q)))
        else $error("unknown vlan not forwarded to mask");
    a_uvlan_disabled: assert property (frame_valid && !uvlan_en_q |=>
        !dec_override && dec_ports == '0)
        else $error("unknown vlan forwarded while disabled");
    a_mask_subset: assert property (dec_valid |->
        (dec_ports & ~$past(uvlan_mask_q)) == '0)
        else $error("port outside mask selected");
    a_alt_half_duplex: assert property (##1 port_alt_backoff ==
        ($past(mac_ctrl0_q[MAC0_ALT_BACKOFF_BIT]) ?
        ~$past(port_full_duplex) : '0))
        else $error("alternate back-off on wrong ports");
    a_len_mismatch: assert property (frame_valid &&
        mac_ctrl0_q[MAC0_LEN_CHECK_BIT] && frame_type_len < LEN_FIELD_LIMIT &&
        frame_payload_len != frame_type_len |=> dec_drop)
        else $error("length mismatch not dropped");
    a_len_unchecked: assert property (frame_valid &&
        !mac_ctrl0_q[MAC0_LEN_CHECK_BIT] && !fc_drop |=> !dec_drop)
        else $error("dropped without length check");
    a_fc_either: assert property (frame_valid &&
        mac_ctrl0_q[MAC0_FC_DROP_MODE_BIT] && (fc_type_hit || fc_addr_hit)
        |=> dec_drop)
        else $error("flow control frame kept in mode one");
    a_fc_both: assert property (frame_valid &&
        !mac_ctrl0_q[MAC0_FC_DROP_MODE_BIT] && !(fc_type_hit && fc_addr_hit)
        && !len_drop |=> !dec_drop)
        else $error("frame dropped in mode zero");
    a_aggr_half_duplex: assert property (##1 port_aggr_backoff ==
        ($past(mac_ctrl0_q[MAC0_AGGR_BACKOFF_BIT]) ?
        ~$past(port_full_duplex) : '0))
        else $error("aggressive back-off on wrong ports");
    a_class_order: assert property (frame_valid && vlan_unknown |=>
        dec_class == CLASS_UNK_VLAN)
        else $error("unknown vlan lost precedence");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");

endmodule : switch_frame_policy_control

// *** test/frame_source.sv ***
`timescale 1ns/1ns
module frame_source (
    input wire logic aclk,
    output logic frame_valid,
    output logic [15:0] frame_type_len,
    output logic [47:0] frame_dest_addr,
    output logic [15:0] frame_payload_len,
    output logic frame_vlan_hit,
    output logic frame_unk_ucast,
    output logic frame_unk_mcast,
    output logic [5:0] port_full_duplex
);
    initial begin
        frame_valid = 1'b0;
        {frame_type_len, frame_dest_addr, frame_payload_len} = '0;
        {frame_vlan_hit, frame_unk_ucast, frame_unk_mcast} = 3'h0;
        port_full_duplex = 6'h3f;
    end
    // ----------------
    // one descriptor for one cycle, then type, address and length are scrambled, the flags hold
    // ----------------
    task automatic send(input logic [15:0] t, input logic [47:0] a,
            input logic [15:0] l, input logic [2:0] f);
        @(posedge aclk);
        frame_valid <= 1'b1;
        frame_type_len <= t;
        frame_dest_addr <= a;
        frame_payload_len <= l;
        {frame_vlan_hit, frame_unk_ucast, frame_unk_mcast} <= f;
        @(posedge aclk);
        frame_valid <= 1'b0;
        frame_type_len <= ~t;
        frame_dest_addr <= ~a;
        frame_payload_len <= ~l;
    endtask : send
    task automatic set_duplex(input logic [5:0] d);
        @(posedge aclk);
        port_full_duplex <= d;
    endtask : set_duplex
endmodule : frame_source

// *** test/switch_frame_policy_control_tb.sv ***
`timescale 1ns/1ns
module switch_frame_policy_control_tb
    import frame_policy_pkg::*;
;
    logic aclk, aresetn;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [1:0] bresp, rresp;
    logic fv, vhit, uu, um, dv, drop, ovr;
    logic [15:0] tl, pl;
    logic [47:0] da;
    logic [5:0] fdx, ports, alt, aggr;
    unknown_class_t cls;
    int err_count = 0;
    int samples_checked = 0;
    logic [3:0] wr_strb = 4'hf;

    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end

    switch_frame_policy_control switch_frame_policy_control_i (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .frame_valid(fv), .frame_type_len(tl), .frame_dest_addr(da),
        .frame_payload_len(pl), .frame_vlan_hit(vhit),
        .frame_unk_ucast(uu), .frame_unk_mcast(um), .port_full_duplex(fdx),
        .dec_valid(dv), .dec_drop(drop), .dec_override(ovr),
        .dec_ports(ports), .dec_class(cls), .port_alt_backoff(alt),
        .port_aggr_backoff(aggr));

    frame_source src_i (
        .aclk(aclk), .frame_valid(fv), .frame_type_len(tl),
        .frame_dest_addr(da), .frame_payload_len(pl),
        .frame_vlan_hit(vhit), .frame_unk_ucast(uu), .frame_unk_mcast(um),
        .port_full_duplex(fdx));

    // ----------------
    // reporting
    // ----------------
    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : summarize
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic hang();
        err_count++;
        $display("wrong value at %0t: no answer", $time);
        summarize();
    endtask : hang

    // ----------------
    // bus cycles and frames
    // ----------------
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
            input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= wr_strb;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 40);
        bready <= 1'b0;
        if (bvalid !== 1'b1) hang();
        chk({30'h0, bresp}, {30'h0, er});
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] ed,
            input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 40);
        rready <= 1'b0;
        if (rvalid !== 1'b1) hang();
        chk(rdata, ed);
        chk({30'h0, rresp}, {30'h0, er});
    endtask : rd
    // e packs drop, override, ports and class
    task automatic fr(input logic [15:0] t, input logic [47:0] a,
            input logic [15:0] l, input logic [2:0] f, input logic [9:0] e);
        src_i.send(t, a, l, f);
        @(negedge aclk);
        chk({31'h0, dv}, 32'h1);
        chk({22'h0, drop, ovr, ports, cls}, {22'h0, e});
    endtask : fr

    initial begin
        aresetn = 1'b0;
        {awaddr, araddr, wdata, wstrb} = '0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        rd(UVLAN_CTRL_OFS, 32'h0, RESP_OKAY);
        rd(MAC_CTRL0_OFS, 32'h4, RESP_OKAY);
        rd(12'h100, 32'h0, RESP_SLVERR);
        wr(12'h100, 32'hffffffff, RESP_SLVERR);
        wr(UVLAN_CTRL_OFS, 32'hffffffff, RESP_OKAY);
        rd(UVLAN_CTRL_OFS, 32'h8000003f, RESP_OKAY);
        fr(16'h800, 48'h0, 16'h0, 3'h0, {2'h1, 6'h3f, CLASS_UNK_VLAN});
        wr(UVLAN_CTRL_OFS, 32'h80000015, RESP_OKAY);
        fr(16'h800, 48'h0, 16'h0, 3'h3, {2'h1, 6'h15, CLASS_UNK_VLAN});
        fr(16'h800, 48'h0, 16'h0, 3'h7, {2'h0, 6'h0, CLASS_UNK_UCAST});
        fr(16'h800, 48'h0, 16'h0, 3'h5, {2'h0, 6'h0, CLASS_UNK_MCAST});
        wr(UVLAN_CTRL_OFS, 32'h3f, RESP_OKAY);
        fr(16'h800, 48'h0, 16'h0, 3'h0, {2'h0, 6'h0, CLASS_UNK_VLAN});
        for (int m = 0; m < 2; m++) begin
            wr(MAC_CTRL0_OFS, {30'h1, m[0], 1'b0}, RESP_OKAY);
            for (int k = 0; k < 4; k++) begin
                fr(k[0] ? FC_ETHERTYPE : 16'h800,
                    k[1] ? FC_DEST_ADDR : 48'h0180c2000002, 16'h0, 3'h4,
                    {m[0] ? k[0] | k[1] : k[0] & k[1], 9'h0});
            end
        end
        wr(MAC_CTRL0_OFS, 32'hc, RESP_OKAY);
        fr(16'h64, 48'h0, 16'h63, 3'h4, 10'h200);
        fr(16'h64, 48'h0, 16'h64, 3'h4, 10'h0);
        fr(16'h5db, 48'h0, 16'h1, 3'h4, 10'h200);
        fr(LEN_FIELD_LIMIT, 48'h0, 16'h1, 3'h4, 10'h0);
        wr(MAC_CTRL0_OFS, 32'h4, RESP_OKAY);
        fr(16'h64, 48'h0, 16'h63, 3'h4, 10'h0);
        src_i.set_duplex(6'h15);
        wr(MAC_CTRL0_OFS, 32'h85, RESP_OKAY);
        repeat (2) @(posedge aclk);
        chk({20'h0, alt, aggr}, {20'h0, 6'h2a, 6'h2a});
        src_i.set_duplex(6'h3c);
        wr(MAC_CTRL0_OFS, 32'h80, RESP_OKAY);
        repeat (2) @(posedge aclk);
        chk({20'h0, alt, aggr}, {20'h0, 6'h03, 6'h00});
        rd(MAC_CTRL0_OFS, 32'h80, RESP_OKAY);
        wr_strb = 4'h1;
        wr(UVLAN_CTRL_OFS, 32'h8000000a, RESP_OKAY);
        rd(UVLAN_CTRL_OFS, 32'h0000000a, RESP_OKAY);
        wr_strb = 4'h8;
        wr(UVLAN_CTRL_OFS, 32'h80000015, RESP_OKAY);
        rd(UVLAN_CTRL_OFS, 32'h8000000a, RESP_OKAY);
        wr(MAC_CTRL0_OFS, 32'h0, RESP_OKAY);
        rd(MAC_CTRL0_OFS, 32'h80, RESP_OKAY);
        wr_strb = 4'hf;
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(UVLAN_CTRL_OFS, 32'h0, RESP_OKAY);
        rd(MAC_CTRL0_OFS, 32'h4, RESP_OKAY);
        chk({20'h0, alt, aggr}, 32'h0);
        summarize();
    end
endmodule : switch_frame_policy_control_tb
